// ### inc/interlock_consts.svh
// Timing constants for the issue interlock logic
`ifndef INTERLOCK_CONSTS_SVH
`define INTERLOCK_CONSTS_SVH

// Result latencies, counted from the first issue cycle
`define LAT_LOAD       3'd3
`define LAT_ALU        3'd1
`define LAT_REG_SHIFT  3'd2
`define LAT_SAT        3'd2
`define LAT_SAD        3'd3

// Highest scoreboard count an operand may show and still be used
`define LIMIT_EARLY    3'd0
`define LIMIT_NORMAL   3'd1
`define LIMIT_LATE     3'd2

// Issue cycles with a non-program-counter destination
`define CYC_SINGLE     4'd1
`define CYC_DOUBLE     4'd2

// Program counter write costs
`define CYC_RET_HIT    4'd4
`define CYC_RET_MISS   4'd7
`define CYC_MOV_MIN    4'd5
`define CYC_MOV_MAX    4'd7
`define CYC_IMM_MIN    4'd6
`define CYC_IMM_MAX    4'd7
`define CYC_MOV_REGSH  4'd7
`define CYC_DP_PLAIN   4'd7
`define CYC_DP_REGSH   4'd8

`endif

// ### inc/interlock_pkg.sv
// Types shared by the issue interlock logic
package interlock_pkg;

  typedef enum logic [3:0] {
    OP_ALU,
    OP_MOVE,
    OP_LOAD,
    OP_SAT,
    OP_DSAT,
    OP_MEDIA_ALU,
    OP_MEDIA_SAT,
    OP_MEDIA_X_ALU,
    OP_MEDIA_X_SAT,
    OP_SAD,
    OP_SADA,
    OP_CLZ
  } op_e;

  typedef enum logic [1:0] {
    SHIFT_NONE,
    SHIFT_IMM,
    SHIFT_REG
  } shift_e;

  typedef enum logic [1:0] {
    ST_OPEN,
    ST_SECOND,
    ST_FLUSH
  } state_e;

endpackage

// ### rtl/issue_hold_counter.sv
// Down counter that holds issue closed while the pipeline refills
module issue_hold_counter #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  // Status
  output logic                  last
);

  logic [WIDTH-1:0] count;
  wire  logic       running = (count != '0);

  generate
    if (WIDTH < 3) begin : g_check
      $error("issue_hold_counter needs at least three bits");
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (running) begin
      count <= count - WIDTH'(1);
    end
  end

  assign last = (count == WIDTH'(1));

endmodule

// ### rtl/issue_interlock.sv
// Issue stage interlock and cycle timing for integer, saturating, media and SAD operations
`include "interlock_consts.svh"
module issue_interlock #(
  parameter int NUM_REGS = 16,
  parameter int REG_BITS = 4,
  parameter int PC_INDEX = 15
) (
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  // Issue request
  input  wire logic                  ISSUE_VALID,
  output logic                       ISSUE_READY,
  input  wire interlock_pkg::op_e    OP_CLASS,
  input  wire interlock_pkg::shift_e SHIFT_KIND,
  // Destination
  input  wire logic                  DEST_WRITE,
  input  wire logic [REG_BITS-1:0]   DEST_REG,
  // Sources
  input  wire logic                  FIRST_USED,
  input  wire logic [REG_BITS-1:0]   FIRST_OPERAND_REG,
  input  wire logic                  SECOND_USED,
  input  wire logic [REG_BITS-1:0]   SECOND_OPERAND_REG,
  input  wire logic                  SHIFT_USED,
  input  wire logic [REG_BITS-1:0]   SHIFT_AMOUNT_REG,
  // Condition and return stack
  input  wire logic                  CONDITIONAL,
  input  wire logic                  COND_PASS,
  input  wire logic [3:0]            FLAG_DISTANCE,
  input  wire logic                  FROM_LINK,
  input  wire logic                  RETURN_HIT,
  input  wire logic                  RETURN_EMPTY,
  // Issue report
  output logic                       ISSUED,
  output logic [3:0]                 ISSUE_CYCLES,
  output logic [2:0]                 RESULT_LATENCY,
  output logic                       UNPREDICTABLE,
  output logic                       INTERLOCK,
  output logic                       SECOND_ISSUE,
  output logic                       PC_REFILL
);
  import interlock_pkg::*;

  generate
    if (NUM_REGS != (1 << REG_BITS) || PC_INDEX >= NUM_REGS) begin : g_check
      $error("issue_interlock register count and index width disagree");
    end
  endgenerate

  localparam logic [REG_BITS-1:0] PC_REG = REG_BITS'(PC_INDEX);

  // Scoreboard: cycles until a register is ready for a normal use, plus one
  logic [2:0] ready_count [NUM_REGS];
  logic       from_sad    [NUM_REGS];

  state_e     state;
  state_e     next_state;

  // Operation decode
  wire logic dp_op       = (OP_CLASS == OP_ALU) || (OP_CLASS == OP_MOVE);
  wire logic reg_shift   = dp_op && (SHIFT_KIND == SHIFT_REG);
  wire logic imm_shift   = dp_op && (SHIFT_KIND == SHIFT_IMM);
  wire logic sad_op      = (OP_CLASS == OP_SAD) || (OP_CLASS == OP_SADA);
  wire logic media_x     = (OP_CLASS == OP_MEDIA_X_ALU) || (OP_CLASS == OP_MEDIA_X_SAT);
  wire logic sat_result  = (OP_CLASS == OP_SAT) || (OP_CLASS == OP_DSAT)
                        || (OP_CLASS == OP_MEDIA_SAT) || (OP_CLASS == OP_MEDIA_X_SAT);
  wire logic pc_dest     = DEST_WRITE && (DEST_REG == PC_REG);
  wire logic clz_to_pc   = pc_dest && (OP_CLASS == OP_CLZ);
  wire logic cost_pc     = pc_dest && dp_op;
  wire logic cond_failed = CONDITIONAL && !COND_PASS;

  // Result latency from the first issue cycle
  wire logic [2:0] op_latency = (OP_CLASS == OP_LOAD) ? `LAT_LOAD
                              : sad_op                ? `LAT_SAD
                              : reg_shift             ? `LAT_REG_SHIFT
                              : sat_result            ? `LAT_SAT
                              :                         `LAT_ALU;

  // Operand need: early uses one cycle more, late one cycle less
  wire logic [2:0] first_limit =
      (OP_CLASS == OP_LOAD)  ? `LIMIT_EARLY
    : (OP_CLASS == OP_DSAT)  ? `LIMIT_EARLY
    : reg_shift              ? `LIMIT_LATE
    : (OP_CLASS == OP_SADA) && from_sad[FIRST_OPERAND_REG] ? `LIMIT_LATE
    :                          `LIMIT_NORMAL;
  wire logic [2:0] second_limit =
      imm_shift              ? `LIMIT_EARLY
    : media_x                ? `LIMIT_EARLY
    : sad_op                 ? `LIMIT_EARLY
    :                          `LIMIT_NORMAL;
  wire logic [2:0] shift_limit =
      reg_shift || sad_op    ? `LIMIT_EARLY
    :                          `LIMIT_NORMAL;

  // Operand availability against the scoreboard
  wire logic first_ok  = !FIRST_USED  || (ready_count[FIRST_OPERAND_REG]  <= first_limit);
  wire logic second_ok = !SECOND_USED || (ready_count[SECOND_OPERAND_REG] <= second_limit);
  wire logic shift_ok  = !SHIFT_USED  || (ready_count[SHIFT_AMOUNT_REG]   <= shift_limit);
  wire logic operands_ok = first_ok && second_ok && shift_ok;

  assign ISSUE_READY = (state == ST_OPEN) && operands_ok;

  wire logic accept = ISSUE_VALID && ISSUE_READY;

  // Total cycle cost of the operation
  logic [3:0] op_cycles;

  pc_write_cost u_cost (
    .is_move       (OP_CLASS == OP_MOVE),
    .from_link     (FROM_LINK),
    .shift_kind    (dp_op ? SHIFT_KIND : SHIFT_NONE),
    .writes_pc     (cost_pc),
    .conditional   (CONDITIONAL),
    .cond_pass     (COND_PASS),
    .flag_distance (FLAG_DISTANCE),
    .return_hit    (RETURN_HIT),
    .return_empty  (RETURN_EMPTY),
    .cycles        (op_cycles)
  );

  wire logic       refill_start = accept && cost_pc && !cond_failed;
  wire logic [3:0] hold_value   = op_cycles - 4'h1;
  logic            hold_last;

  issue_hold_counter #(
    .WIDTH (4)
  ) u_hold (
    .clk        (CLOCK),
    .rst        (RST),
    .load       (refill_start),
    .load_value (hold_value),
    .last       (hold_last)
  );

  // Issue sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OPEN: begin
        if (refill_start) begin
          next_state = ST_FLUSH;
        end else if (accept && reg_shift) begin
          next_state = ST_SECOND;
        end
      end
      ST_SECOND: begin
        next_state = ST_OPEN;
      end
      ST_FLUSH: begin
        if (hold_last) begin
          next_state = ST_OPEN;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= ST_OPEN;
    end else begin
      state <= next_state;
    end
  end

  // Scoreboard entries count down each cycle until zero; non-pc writes whose condition did not fail set the latency
  wire logic sb_write = accept && DEST_WRITE && !pc_dest && !cond_failed;

  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_sb
      wire logic hit = sb_write && (DEST_REG == REG_BITS'(r));
      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          ready_count[r] <= 3'h0;
          from_sad[r]    <= 1'b0;
        end else if (hit) begin
          ready_count[r] <= op_latency;
          from_sad[r]    <= sad_op;
        end else if (ready_count[r] != 3'h0) begin
          ready_count[r] <= ready_count[r] - 3'h1;
        end
      end
    end
  endgenerate

  // Issue report registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ISSUED         <= 1'b0;
      ISSUE_CYCLES   <= 4'h0;
      RESULT_LATENCY <= 3'h0;
      UNPREDICTABLE  <= 1'b0;
      INTERLOCK      <= 1'b0;
    end else begin
      ISSUED         <= accept;
      INTERLOCK      <= ISSUE_VALID && (state == ST_OPEN) && !operands_ok;
      if (accept) begin
        ISSUE_CYCLES   <= op_cycles;
        RESULT_LATENCY <= pc_dest ? 3'h0 : op_latency;
        UNPREDICTABLE  <= clz_to_pc;
      end
    end
  end

  assign SECOND_ISSUE = (state == ST_SECOND);
  assign PC_REFILL    = (state == ST_FLUSH);

endmodule

// ### rtl/pc_write_cost.sv
// Cycle cost of one issued operation, including program counter writes
`include "interlock_consts.svh"
module pc_write_cost (
  // Operation
  input  wire logic                 is_move,
  input  wire logic                 from_link,
  input  wire interlock_pkg::shift_e shift_kind,
  input  wire logic                 writes_pc,
  // Condition
  input  wire logic                 conditional,
  input  wire logic                 cond_pass,
  input  wire logic [3:0]           flag_distance,
  // Return stack
  input  wire logic                 return_hit,
  input  wire logic                 return_empty,
  // Result
  output logic [3:0]                cycles
);
  import interlock_pkg::*;

  wire logic       reg_shift  = (shift_kind == SHIFT_REG);
  wire logic       imm_shift  = (shift_kind == SHIFT_IMM);
  wire logic [3:0] non_pc     = reg_shift ? `CYC_DOUBLE : `CYC_SINGLE;
  wire logic       link_ret   = is_move && from_link && (shift_kind == SHIFT_NONE);
  // Smallest and largest cost of the program counter forms
  wire logic [3:0] min_cost   = link_ret && !conditional && !return_empty
                                ? (return_hit ? `CYC_RET_HIT : `CYC_RET_MISS)
                              : is_move && reg_shift ? `CYC_MOV_REGSH
                              : is_move && imm_shift ? `CYC_IMM_MIN
                              : is_move              ? `CYC_MOV_MIN
                              : reg_shift            ? `CYC_DP_REGSH
                              :                        `CYC_DP_PLAIN;
  wire logic [3:0] max_cost   = link_ret && !conditional && !return_empty ? min_cost
                              : is_move && reg_shift ? `CYC_MOV_REGSH
                              : is_move && imm_shift ? `CYC_IMM_MAX
                              : is_move              ? `CYC_MOV_MAX
                              : reg_shift            ? `CYC_DP_REGSH
                              :                        `CYC_DP_PLAIN;
  // Larger of max minus flag distance and min
  wire logic [3:0] reduced    = (flag_distance >= max_cost) ? 4'h0 : max_cost - flag_distance;
  wire logic [3:0] cond_cost  = (reduced > min_cost) ? reduced : min_cost;
  wire logic       failed     = conditional && !cond_pass;

  assign cycles = !writes_pc || failed ? non_pc
                : conditional          ? cond_cost
                :                        min_cost;

endmodule

// ### verif/issue_interlock_sva.sv
// Port assertions for the issue interlock
module issue_interlock_sva
  import interlock_pkg::*;
(
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST,
  // Issue request
  input wire logic       ISSUE_VALID,
  input wire logic       ISSUE_READY,
  input wire op_e        OP_CLASS,
  input wire shift_e     SHIFT_KIND,
  input wire logic       DEST_WRITE,
  input wire logic [3:0] DEST_REG,
  input wire logic       CONDITIONAL,
  input wire logic       COND_PASS,
  input wire logic       FROM_LINK,
  // Issue report
  input wire logic       ISSUED,
  input wire logic [3:0] ISSUE_CYCLES,
  input wire logic [2:0] RESULT_LATENCY,
  input wire logic       UNPREDICTABLE,
  input wire logic       INTERLOCK,
  input wire logic       SECOND_ISSUE,
  input wire logic       PC_REFILL
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Accept, and a plain unconditional non-pc destination
  wire acc = ISSUE_VALID && ISSUE_READY;
  wire npc = DEST_WRITE && DEST_REG != 4'hF && !CONDITIONAL;
  wire tpc = acc && DEST_WRITE && DEST_REG == 4'hF;

  chk_issue_pulse: assert property (acc |=> ISSUED)
    else $error("accepted operation not reported");
  chk_no_issue: assert property (!acc |=> !ISSUED)
    else $error("report without accept");
  chk_load_lat: assert property (acc && OP_CLASS == OP_LOAD && npc
    |=> ISSUE_CYCLES == 4'h1 && RESULT_LATENCY == 3'h3) else $error("load timing wrong");
  chk_alu_lat: assert property (acc && OP_CLASS == OP_ALU && SHIFT_KIND != SHIFT_REG && npc
    |=> ISSUE_CYCLES == 4'h1 && RESULT_LATENCY == 3'h1) else $error("alu timing wrong");
  chk_sat_lat: assert property (acc && npc && OP_CLASS inside
    {OP_SAT, OP_DSAT, OP_MEDIA_SAT, OP_MEDIA_X_SAT} |=> RESULT_LATENCY == 3'h2)
    else $error("saturate latency wrong");
  chk_sad_lat: assert property (acc && npc && OP_CLASS inside {OP_SAD, OP_SADA}
    |=> RESULT_LATENCY == 3'h3 && ISSUE_CYCLES == 4'h1) else $error("sad timing wrong");
  chk_reg_shift: assert property (acc && OP_CLASS == OP_ALU && SHIFT_KIND == SHIFT_REG && npc
    |=> SECOND_ISSUE && !ISSUE_READY && RESULT_LATENCY == 3'h2 ##1 !SECOND_ISSUE)
    else $error("register shift issue wrong");
  chk_mov_cost: assert property (tpc && OP_CLASS == OP_MOVE && SHIFT_KIND == SHIFT_NONE
    && !FROM_LINK && !CONDITIONAL |=> (PC_REFILL && ISSUE_CYCLES == 4'h5 && !ISSUE_READY)
    ##1 (!ISSUE_READY) [*3] ##1 !PC_REFILL) else $error("move to pc cost wrong");
  chk_fail_cost: assert property (acc && OP_CLASS inside {OP_ALU, OP_MOVE} && CONDITIONAL
    && !COND_PASS && SHIFT_KIND != SHIFT_REG |=> ISSUE_CYCLES == 4'h1 && !PC_REFILL)
    else $error("failing operation cost wrong");
  chk_clz_pc: assert property (tpc && OP_CLASS == OP_CLZ |=> UNPREDICTABLE)
    else $error("clz to pc not flagged");
  chk_stall_flag: assert property (ISSUE_VALID && !ISSUE_READY && !SECOND_ISSUE
    && !PC_REFILL |=> INTERLOCK) else $error("stall not flagged");
endmodule

bind issue_interlock issue_interlock_sva i_issue_interlock_sva (.CLOCK, .RST, .ISSUE_VALID,
  .ISSUE_READY, .OP_CLASS, .SHIFT_KIND, .DEST_WRITE, .DEST_REG, .CONDITIONAL, .COND_PASS,
  .FROM_LINK, .ISSUED, .ISSUE_CYCLES, .RESULT_LATENCY, .UNPREDICTABLE, .INTERLOCK,
  .SECOND_ISSUE, .PC_REFILL);

// ### verif/issue_interlock_tb.sv
// Self-checking testbench for the issue interlock
module issue_interlock_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import interlock_pkg::*;
  logic       CLOCK = 0, RST = 1, ISSUE_VALID = 0, DEST_WRITE = 0, FIRST_USED = 0;
  logic       SECOND_USED = 0, SHIFT_USED = 0, CONDITIONAL = 0, COND_PASS = 0;
  logic       FROM_LINK = 0, RETURN_HIT = 0, RETURN_EMPTY = 0;
  logic [3:0] DEST_REG = 0, FIRST_OPERAND_REG = 0, SECOND_OPERAND_REG = 0;
  logic [3:0] SHIFT_AMOUNT_REG = 0, FLAG_DISTANCE = 0, ISSUE_CYCLES;
  logic [2:0] RESULT_LATENCY;
  logic       ISSUE_READY, ISSUED, UNPREDICTABLE, INTERLOCK, SECOND_ISSUE, PC_REFILL;
  op_e        OP_CLASS = OP_ALU;
  shift_e     SHIFT_KIND = SHIFT_NONE;
  int         n_errors = 0, n_compared = 0, cyc = 0, t_acc = 0, t_prev = 0;

  issue_interlock i_issue_interlock (.CLOCK, .RST, .ISSUE_VALID, .ISSUE_READY, .OP_CLASS,
    .SHIFT_KIND, .DEST_WRITE, .DEST_REG, .FIRST_USED, .FIRST_OPERAND_REG, .SECOND_USED,
    .SECOND_OPERAND_REG, .SHIFT_USED, .SHIFT_AMOUNT_REG, .CONDITIONAL, .COND_PASS,
    .FLAG_DISTANCE, .FROM_LINK, .RETURN_HIT, .RETURN_EMPTY, .ISSUED, .ISSUE_CYCLES,
    .RESULT_LATENCY, .UNPREDICTABLE, .INTERLOCK, .SECOND_ISSUE, .PC_REFILL);

  always #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) cyc <= cyc + 1;

  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Offer one operation at a falling edge, hold it until taken; register 0 means unused
  task automatic op(op_e o, shift_e s, logic [3:0] d, f, m, r, ec, logic [2:0] el);
    int n;
    OP_CLASS = o;
    SHIFT_KIND = s;
    DEST_WRITE = d != 0;
    DEST_REG = d;
    FIRST_USED = f != 0;
    FIRST_OPERAND_REG = f;
    SECOND_USED = m != 0;
    SECOND_OPERAND_REG = m;
    SHIFT_USED = r != 0;
    SHIFT_AMOUNT_REG = r;
    ISSUE_VALID = 1;
    n = 0;
    #1;
    while (ISSUE_READY !== 1'b1 && n < 40) begin
      @(negedge CLOCK);
      #1;
      n++;
    end
    t_prev = t_acc;
    t_acc = cyc;
    @(negedge CLOCK);
    check("issued", ISSUED, 1);
    check("cycles", ISSUE_CYCLES, ec);
    if (el != 3'h7) check("latency", RESULT_LATENCY, el);
  endtask

  task automatic g(logic [7:0] e);
    check("gap", t_acc - t_prev, e);
  endtask

  task automatic idle();
    ISSUE_VALID = 0;
    repeat (8) @(negedge CLOCK);
  endtask

  // Program counter write followed by an independent operation
  task automatic pc(op_e o, shift_e s, logic c, p, logic [3:0] fd, logic l, h, e, logic [3:0] x);
    CONDITIONAL = c;
    COND_PASS = p;
    FLAG_DISTANCE = fd;
    FROM_LINK = l;
    RETURN_HIT = h;
    RETURN_EMPTY = e;
    op(o, s, 15, 2, 3, (s == SHIFT_REG) ? 4'h4 : 4'h0, x, (c && !p) ? 3'h7 : 3'h0);
    CONDITIONAL = 0;
    FROM_LINK = 0;
    op(OP_ALU, SHIFT_NONE, 8, 9, 10, 0, 1, 1);
    g(x);
    idle();
  endtask

  task automatic t_load();
    op(OP_LOAD, SHIFT_NONE, 1, 2, 0, 0, 1, 3);
    op(OP_ALU, SHIFT_NONE, 6, 5, 4, 0, 1, 1);
    g(1);
    idle();
    op(OP_LOAD, SHIFT_NONE, 1, 2, 0, 0, 1, 3);
    op(OP_ALU, SHIFT_NONE, 6, 5, 1, 0, 1, 1);
    g(3);
    idle();
    op(OP_LOAD, SHIFT_NONE, 1, 2, 0, 0, 1, 3);
    op(OP_LOAD, SHIFT_NONE, 5, 1, 0, 0, 1, 3);
    g(4);
    idle();
    op(OP_ALU, SHIFT_NONE, 2, 5, 6, 0, 1, 1);
    op(OP_LOAD, SHIFT_NONE, 1, 2, 0, 0, 1, 3);
    g(2);
    idle();
  endtask

  task automatic t_alu();
    op(OP_ALU, SHIFT_NONE, 1, 2, 3, 0, 1, 1);
    op(OP_ALU, SHIFT_NONE, 9, 6, 1, 0, 1, 1);
    g(1);
    op(OP_ALU, SHIFT_IMM, 4, 5, 9, 0, 1, 1);
    g(2);
    op(OP_ALU, SHIFT_IMM, 7, 4, 10, 0, 1, 1);
    g(1);
    idle();
  endtask

  task automatic t_regsh();
    op(OP_ALU, SHIFT_NONE, 1, 2, 3, 0, 1, 1);
    op(OP_ALU, SHIFT_REG, 4, 2, 4, 1, 2, 2);
    g(2);
    op(OP_ALU, SHIFT_NONE, 5, 6, 4, 0, 1, 1);
    g(2);
    idle();
    op(OP_LOAD, SHIFT_NONE, 1, 2, 0, 0, 1, 3);
    op(OP_ALU, SHIFT_REG, 4, 1, 5, 3, 2, 2);
    g(2);
    idle();
  endtask

  task automatic t_sat();
    op(OP_SAT, SHIFT_NONE, 1, 2, 3, 0, 1, 2);
    op(OP_ALU, SHIFT_NONE, 5, 6, 1, 0, 1, 1);
    g(2);
    op(OP_DSAT, SHIFT_NONE, 7, 5, 3, 0, 1, 2);
    g(2);
    op(OP_MEDIA_ALU, SHIFT_NONE, 1, 2, 3, 0, 1, 1);
    op(OP_ALU, SHIFT_NONE, 5, 6, 1, 0, 1, 1);
    g(1);
    op(OP_MEDIA_SAT, SHIFT_NONE, 1, 2, 3, 0, 1, 2);
    op(OP_ALU, SHIFT_NONE, 5, 6, 1, 0, 1, 1);
    g(2);
    op(OP_MEDIA_X_ALU, SHIFT_NONE, 7, 2, 5, 0, 1, 1);
    g(2);
    op(OP_MEDIA_X_SAT, SHIFT_NONE, 8, 2, 7, 0, 1, 2);
    g(2);
    idle();
  endtask

  task automatic t_sad();
    op(OP_SAD, SHIFT_NONE, 1, 0, 2, 3, 1, 3);
    op(OP_ALU, SHIFT_NONE, 5, 6, 1, 0, 1, 1);
    g(3);
    op(OP_SAD, SHIFT_NONE, 1, 0, 5, 3, 1, 3);
    g(2);
    op(OP_SADA, SHIFT_NONE, 1, 1, 4, 5, 1, 3);
    g(2);
    idle();
    op(OP_SAD, SHIFT_NONE, 1, 0, 2, 3, 1, 3);
    op(OP_MOVE, SHIFT_NONE, 9, 0, 9, 0, 1, 1);
    op(OP_MOVE, SHIFT_NONE, 9, 0, 9, 0, 1, 1);
    op(OP_ALU, SHIFT_NONE, 5, 6, 1, 0, 1, 1);
    g(1);
    check("span", t_acc - t_prev + 2, 3);
    idle();
  endtask

  task automatic t_pc();
    pc(OP_MOVE, SHIFT_NONE, 0, 1, 0, 1, 1, 0, 4);
    pc(OP_MOVE, SHIFT_NONE, 0, 1, 0, 1, 0, 0, 7);
    pc(OP_MOVE, SHIFT_NONE, 0, 1, 0, 1, 0, 1, 5);
    pc(OP_MOVE, SHIFT_NONE, 1, 1, 1, 1, 0, 0, 6);
    pc(OP_MOVE, SHIFT_NONE, 0, 1, 0, 0, 0, 0, 5);
    pc(OP_MOVE, SHIFT_NONE, 1, 1, 0, 0, 0, 0, 7);
    pc(OP_MOVE, SHIFT_NONE, 1, 1, 9, 0, 0, 0, 5);
    pc(OP_MOVE, SHIFT_IMM, 0, 1, 0, 0, 0, 0, 6);
    pc(OP_MOVE, SHIFT_IMM, 1, 1, 0, 0, 0, 0, 7);
    pc(OP_MOVE, SHIFT_REG, 0, 1, 0, 0, 0, 0, 7);
    pc(OP_ALU, SHIFT_NONE, 0, 1, 0, 0, 0, 0, 7);
    pc(OP_ALU, SHIFT_IMM, 0, 1, 0, 0, 0, 0, 7);
    pc(OP_ALU, SHIFT_REG, 0, 1, 0, 0, 0, 0, 8);
    pc(OP_ALU, SHIFT_NONE, 1, 0, 0, 0, 0, 0, 1);
    pc(OP_MOVE, SHIFT_REG, 1, 0, 0, 0, 0, 0, 2);
  endtask

  task automatic t_clz();
    op(OP_CLZ, SHIFT_NONE, 15, 2, 0, 0, 1, 0);
    check("unpredictable", UNPREDICTABLE, 1);
    op(OP_CLZ, SHIFT_NONE, 3, 2, 0, 0, 1, 1);
    check("unpredictable", UNPREDICTABLE, 0);
    idle();
  endtask

  initial begin
    #125000;
    n_errors++;
    results();
  end

  initial begin
    repeat (8) @(negedge CLOCK);
    RST = 0;
    @(negedge CLOCK);
    t_load();
    t_alu();
    t_regsh();
    t_sat();
    t_sad();
    t_pc();
    t_clz();
    results();
  end
endmodule
